// ### core/acl_cond_eval.sv
// any/no/yes condition evaluator for one header property
`timescale 1ns/1ps

module acl_cond_eval
(
   input  wire logic [1:0] sel_i,
   input  wire logic       present_i,
   output logic            ok_o
);
   import acl_pkg::*;

   // ==========================================================
   // condition
   // unknown selector codes never match, so a bad write cannot widen the entry
   always_comb
   begin
      case (sel_i)
         ACL_TRI_ANY : ok_o = 1'b1;
         ACL_TRI_NO  : ok_o = ~present_i;
         ACL_TRI_YES : ok_o = present_i;
         default     : ok_o = 1'b0;
      endcase
   end

endmodule

// ### core/acl_entry_matcher.sv
// access control entry matcher for ipv4 headers with apb configuration
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps

// Contract
// - protocol any ignores protocol number
// - specific protocol requires exact number match
// - icmp/udp/tcp restrict protocol, enable sub-parameters
// - ttl zero rejects frames with ttl above zero
// - ttl non-zero accepts ttl above zero
// - fragment no rejects fragmented frames
// - fragment yes accepts fragmented frames
// - options no rejects frames with options
// - options yes accepts frames with options
// - ttl, fragment, options each offer any
// - source any ignores source address
// - source host requires exact address match
// - source network compares only masked bits
module acl_entry_matcher
(
   input  wire logic                      ref_clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      psel_i,
   input  wire logic                      penable_i,
   input  wire logic                      pwrite_i,
   input  wire logic [11:0]               paddr_i,
   input  wire logic [31:0]               pwdata_i,
   input  wire logic [3:0]                pstrb_i,
   output logic      [31:0]               prdata_o,
   output logic                           pready_o,
   output logic                           pslverr_o,
   input  wire acl_pkg::acl_hdr_s         hdr_i,
   output logic                           hit_valid_o,
   output logic                           hit_o,
   output logic      [2:0]                subparam_en_o
);
   import acl_pkg::*;

   // ==========================================================
   // declarations
   logic [31:0]              ctrl;
   logic [31:0]              src_match;
   logic [31:0]              src_mask;
   logic [31:0]              hit_count;
   logic [31:0]              frame_count;
   acl_cfg_s                 cfg;
   logic                     bus_setup;
   logic                     bus_write;
   logic                     sel_ctrl;
   logic                     sel_addr;
   logic                     sel_mask;
   logic                     sel_hits;
   logic                     sel_frames;
   logic                     sel_status;
   logic                     addr_hit;
   logic [31:0]              rd_value;
   logic                     proto_ok;
   logic                     src_ok;
   logic [ACL_N_TRI-1:0]     tri_sel_ok;
   logic [ACL_N_TRI-1:0]     tri_present;
   logic [2*ACL_N_TRI-1:0]   tri_sel;
   logic                     next_hit;
   logic [ACL_N_SUB-1:0]     next_sub;

   // merge write data into a register under the byte strobes
   function automatic logic [31:0] merge_strb
   (
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  strb
   );
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   // ==========================================================
   // apb phases; zero wait states
   assign pready_o  = 1'b1;
   assign bus_setup = psel_i & ~penable_i;
   assign bus_write = psel_i & penable_i & pwrite_i;

   // address decode
   always_comb
   begin
      sel_ctrl   = 1'b0;
      sel_addr   = 1'b0;
      sel_mask   = 1'b0;
      sel_hits   = 1'b0;
      sel_frames = 1'b0;
      sel_status = 1'b0;
      if (paddr_i == ACL_OFS_CTRL)
      begin
         sel_ctrl = 1'b1;
      end
      else if (paddr_i == ACL_OFS_ADDR)
      begin
         sel_addr = 1'b1;
      end
      else if (paddr_i == ACL_OFS_MASK)
      begin
         sel_mask = 1'b1;
      end
      else if (paddr_i == ACL_OFS_HITS)
      begin
         sel_hits = 1'b1;
      end
      else if (paddr_i == ACL_OFS_FRAMES)
      begin
         sel_frames = 1'b1;
      end
      else if (paddr_i == ACL_OFS_STATUS)
      begin
         sel_status = 1'b1;
      end
   end

   assign addr_hit = sel_ctrl | sel_addr | sel_mask | sel_hits | sel_frames | sel_status;

   // read mux; status shows last result and sub-parameter enables
   always_comb
   begin
      rd_value = 32'h00000000;
      if (sel_ctrl)
      begin
         rd_value = ctrl;
      end
      else if (sel_addr)
      begin
         rd_value = src_match;
      end
      else if (sel_mask)
      begin
         rd_value = src_mask;
      end
      else if (sel_hits)
      begin
         rd_value = hit_count;
      end
      else if (sel_frames)
      begin
         rd_value = frame_count;
      end
      else if (sel_status)
      begin
         rd_value = {27'h0000000, subparam_en_o, hit_o, hit_valid_o};
      end
   end

   // read data and error captured in the setup cycle, held through access
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prdata_o  <= 32'h00000000;
         pslverr_o <= 1'b0;
      end
      else if (bus_setup)
      begin
         prdata_o  <= pwrite_i ? 32'h00000000 : rd_value;
         pslverr_o <= ~addr_hit;
      end
   end

   // ==========================================================
   // configuration registers
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl      <= ACL_CTRL_RST;
         src_match <= ACL_ADDR_RST;
         src_mask  <= ACL_MASK_RST;
      end
      else if (bus_write)
      begin
         if (sel_ctrl)
         begin
            ctrl <= merge_strb(ctrl, pwdata_i, pstrb_i) & ACL_CTRL_WMASK;
         end
         if (sel_addr)
         begin
            src_match <= merge_strb(src_match, pwdata_i, pstrb_i);
         end
         if (sel_mask)
         begin
            src_mask <= merge_strb(src_mask, pwdata_i, pstrb_i);
         end
      end
   end

   // unpack control fields into the configuration carrier
   assign cfg.proto_sel = ctrl[ACL_PSEL_LSB +: 3];
   assign cfg.proto_val = ctrl[ACL_PVAL_LSB +: 8];
   assign cfg.ttl_sel   = ctrl[ACL_TTL_LSB +: 2];
   assign cfg.frag_sel  = ctrl[ACL_FRAG_LSB +: 2];
   assign cfg.opt_sel   = ctrl[ACL_OPT_LSB +: 2];
   assign cfg.src_sel   = ctrl[ACL_SRC_LSB +: 2];
   assign cfg.src_match = src_match;
   assign cfg.src_mask  = src_mask;

   // ==========================================================
   // protocol condition and sub-parameter enables
   always_comb
   begin
      proto_ok = 1'b0;
      next_sub = '0;
      case (cfg.proto_sel)
         ACL_PROTO_ANY      : proto_ok = 1'b1;
         ACL_PROTO_SPECIFIC : proto_ok = (hdr_i.protocol == cfg.proto_val);
         ACL_PROTO_ICMP     :
         begin
            proto_ok               = (hdr_i.protocol == ACL_IP_ICMP);
            next_sub[ACL_SUB_ICMP] = 1'b1;
         end
         ACL_PROTO_UDP      :
         begin
            proto_ok              = (hdr_i.protocol == ACL_IP_UDP);
            next_sub[ACL_SUB_UDP] = 1'b1;
         end
         ACL_PROTO_TCP      :
         begin
            proto_ok              = (hdr_i.protocol == ACL_IP_TCP);
            next_sub[ACL_SUB_TCP] = 1'b1;
         end
         default            : proto_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // ttl, fragment and options conditions
   assign tri_present[ACL_C_TTL]  = (hdr_i.ttl != 8'h00);
   assign tri_present[ACL_C_FRAG] = hdr_i.more_frag |
                                    (hdr_i.fragment_offset_field != 13'h0000);
   assign tri_present[ACL_C_OPT]  = hdr_i.options;
   assign tri_sel = {cfg.opt_sel, cfg.frag_sel, cfg.ttl_sel};

   // one evaluator per condition, each with its own any setting
   generate
      for (genvar c = 0; c < ACL_N_TRI; c++)
      begin : g_cond
         acl_cond_eval u_eval
         (
            .sel_i     (tri_sel[2*c +: 2]),
            .present_i (tri_present[c]),
            .ok_o      (tri_sel_ok[c])
         );
      end
   endgenerate

   // ==========================================================
   // source address filter
   always_comb
   begin
      case (cfg.src_sel)
         ACL_SRC_ANY  : src_ok = 1'b1;
         ACL_SRC_HOST : src_ok = (hdr_i.src_addr == cfg.src_match);
         ACL_SRC_NET  : src_ok = ((hdr_i.src_addr ^ cfg.src_match) & cfg.src_mask) == 32'h0;
         default      : src_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // result stage; the parser strobe qualifies every field
   assign next_hit = hdr_i.valid & hdr_i.is_ipv4 & proto_ok & (&tri_sel_ok) & src_ok;

   // hit registered one clock after the header strobe
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hit_valid_o   <= 1'b0;
         hit_o         <= 1'b0;
         subparam_en_o <= '0;
      end
      else
      begin
         hit_valid_o   <= hdr_i.valid;
         hit_o         <= next_hit;
         subparam_en_o <= next_sub;
      end
   end

   // counters; a write clears, a same-cycle event still counts
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hit_count   <= ACL_CNT_RST;
         frame_count <= ACL_CNT_RST;
      end
      else
      begin
         if (bus_write && sel_hits)
         begin
            hit_count <= {31'h00000000, next_hit};
         end
         else if (next_hit)
         begin
            hit_count <= hit_count + 32'h00000001;
         end
         if (bus_write && sel_frames)
         begin
            frame_count <= {31'h00000000, hdr_i.valid};
         end
         else if (hdr_i.valid)
         begin
            frame_count <= frame_count + 32'h00000001;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   a_result_latency: assert property (
      hdr_i.valid |=> hit_valid_o ##0 (hit_o == $past(next_hit)))
      else $error("hit result not one clock after header strobe");

   a_non_ipv4_miss: assert property (
      (!hdr_i.valid || !hdr_i.is_ipv4) |=> !hit_o)
      else $error("hit without a valid ipv4 header");

   a_all_any_hit: assert property (
      (hdr_i.valid && hdr_i.is_ipv4 && ctrl == ACL_CTRL_RST) |=> hit_o)
      else $error("all-any entry failed to hit");

   a_proto_exact: assert property (
      (hit_o && $past(cfg.proto_sel) == ACL_PROTO_SPECIFIC)
      |-> $past(hdr_i.protocol) == $past(cfg.proto_val))
      else $error("specific protocol hit with wrong number");

   a_proto_named: assert property (
      (hit_o && $past(cfg.proto_sel) == ACL_PROTO_TCP) |-> $past(hdr_i.protocol) == ACL_IP_TCP
      ##0 subparam_en_o == 3'h4)
      else $error("tcp selection hit on other protocol");

   a_ttl_zero: assert property (
      (hit_o && $past(cfg.ttl_sel) == ACL_TRI_NO) |-> $past(hdr_i.ttl) == 8'h00)
      else $error("ttl zero entry hit non-zero ttl");

   a_ttl_nonzero: assert property (
      (hit_o && $past(cfg.ttl_sel) == ACL_TRI_YES) |-> $past(hdr_i.ttl) != 8'h00)
      else $error("ttl non-zero entry hit zero ttl");

   a_frag_no: assert property (
      (hit_o && $past(cfg.frag_sel) == ACL_TRI_NO)
      |-> !$past(hdr_i.more_frag) && $past(hdr_i.fragment_offset_field) == 13'h0000)
      else $error("unfragmented entry hit a fragment");

   a_options_no: assert property (
      (hit_o && $past(cfg.opt_sel) == ACL_TRI_NO) |-> !$past(hdr_i.options))
      else $error("no-options entry hit frame with options");

   a_source_mask: assert property (
      (hit_o && $past(cfg.src_sel) == ACL_SRC_NET)
      |-> (($past(hdr_i.src_addr) ^ $past(src_match)) & $past(src_mask)) == 32'h0)
      else $error("network source hit outside mask");

   a_source_host: assert property (
      (hit_o && $past(cfg.src_sel) == ACL_SRC_HOST) |-> $past(hdr_i.src_addr) == $past(src_match))
      else $error("host source hit wrong address");

endmodule

// ### core/acl_pkg.sv
// shared constants, selector encodings and carriers for the access control entry matcher
package acl_pkg;

   // ==========================================================
   // bus geometry
   localparam int             ACL_ADDR_W     = 12;
   localparam int             ACL_DATA_W     = 32;
   localparam int             ACL_STRB_W     = 4;

   // ==========================================================
   // register byte offsets
   localparam logic [11:0]    ACL_OFS_CTRL   = 12'h000;
   localparam logic [11:0]    ACL_OFS_ADDR   = 12'h004;
   localparam logic [11:0]    ACL_OFS_MASK   = 12'h008;
   localparam logic [11:0]    ACL_OFS_HITS   = 12'h00C;
   localparam logic [11:0]    ACL_OFS_FRAMES = 12'h010;
   localparam logic [11:0]    ACL_OFS_STATUS = 12'h014;

   // ==========================================================
   // control register field positions
   localparam int             ACL_PSEL_LSB   = 0;
   localparam int             ACL_PVAL_LSB   = 8;
   localparam int             ACL_TTL_LSB    = 16;
   localparam int             ACL_FRAG_LSB   = 18;
   localparam int             ACL_OPT_LSB    = 20;
   localparam int             ACL_SRC_LSB    = 22;
   localparam logic [31:0]    ACL_CTRL_WMASK = 32'h00FFFF07;

   // ==========================================================
   // reset values
   localparam logic [31:0]    ACL_CTRL_RST   = 32'h00000000;
   localparam logic [31:0]    ACL_ADDR_RST   = 32'h00000000;
   localparam logic [31:0]    ACL_MASK_RST   = 32'hFFFFFFFF;
   localparam logic [31:0]    ACL_CNT_RST    = 32'h00000000;

   // ==========================================================
   // transport protocol numbers
   localparam logic [7:0]     ACL_IP_ICMP    = 8'h01;
   localparam logic [7:0]     ACL_IP_TCP     = 8'h06;
   localparam logic [7:0]     ACL_IP_UDP     = 8'h11;

   // ==========================================================
   // sub-parameter enable bit positions and tri-state condition slots
   localparam int             ACL_SUB_ICMP   = 0;
   localparam int             ACL_SUB_UDP    = 1;
   localparam int             ACL_SUB_TCP    = 2;
   localparam int             ACL_N_SUB      = 3;
   localparam int             ACL_C_TTL      = 0;
   localparam int             ACL_C_FRAG     = 1;
   localparam int             ACL_C_OPT      = 2;
   localparam int             ACL_N_TRI      = 3;

   // ==========================================================
   // selector encodings
   typedef enum logic [2:0]
   {
      ACL_PROTO_ANY      = 3'h0,
      ACL_PROTO_SPECIFIC = 3'h1,
      ACL_PROTO_ICMP     = 3'h2,
      ACL_PROTO_UDP      = 3'h3,
      ACL_PROTO_TCP      = 3'h4
   } acl_proto_e;

   // ttl: no means zero, yes means non-zero
   typedef enum logic [1:0]
   {
      ACL_TRI_ANY = 2'h0,
      ACL_TRI_NO  = 2'h1,
      ACL_TRI_YES = 2'h2
   } acl_tri_e;

   typedef enum logic [1:0]
   {
      ACL_SRC_ANY  = 2'h0,
      ACL_SRC_HOST = 2'h1,
      ACL_SRC_NET  = 2'h2
   } acl_src_e;

   // ==========================================================
   // carriers
   typedef struct packed
   {
      logic        valid;
      logic        is_ipv4;
      logic [7:0]  protocol;
      logic [7:0]  ttl;
      logic        more_frag;
      logic [12:0] fragment_offset_field;
      logic        options;
      logic [31:0] src_addr;
   } acl_hdr_s;

   typedef struct packed
   {
      logic [2:0]  proto_sel;
      logic [7:0]  proto_val;
      logic [1:0]  ttl_sel;
      logic [1:0]  frag_sel;
      logic [1:0]  opt_sel;
      logic [1:0]  src_sel;
      logic [31:0] src_match;
      logic [31:0] src_mask;
   } acl_cfg_s;

endpackage

// ### sim/acl_entry_matcher_tb.sv
// self-checking bench for the access control entry matcher
`timescale 1ns/1ps

module acl_entry_matcher_tb;
   import acl_pkg::*;

   localparam logic        HI    = 1'b1;
   localparam logic        LO    = 1'b0;
   localparam logic [1:0]  TA    = ACL_TRI_ANY;
   localparam logic [1:0]  TN    = ACL_TRI_NO;
   localparam logic [1:0]  TY    = ACL_TRI_YES;
   localparam logic [31:0] SRC   = 32'hC0A80A05;
   localparam int          LIMIT = 5000;

   logic              ref_clk_i;
   logic              rst_i;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [11:0]       paddr;
   logic [31:0]       pwdata;
   logic [3:0]        pstrb;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   acl_hdr_s          hdr;
   logic              hit_valid;
   logic              hit;
   logic [2:0]        subparam_en;
   logic [31:0]       rd_word;
   logic              rd_err;
   logic [7:0]        proto_num [3];
   logic [2:0]        psel_code;
   int                fails;
   int                tests_run;
   int                cycles = 0;

   // ==========================================================
   // design and parser model
   acl_entry_matcher u_acl_entry_matcher
   (
      .ref_clk_i     (ref_clk_i),
      .rst_i         (rst_i),
      .psel_i        (psel),
      .penable_i     (penable),
      .pwrite_i      (pwrite),
      .paddr_i       (paddr),
      .pwdata_i      (pwdata),
      .pstrb_i       (pstrb),
      .prdata_o      (prdata),
      .pready_o      (pready),
      .pslverr_o     (pslverr),
      .hdr_i         (hdr),
      .hit_valid_o   (hit_valid),
      .hit_o         (hit),
      .subparam_en_o (subparam_en)
   );

   acl_hdr_src_model u_acl_hdr_src_model
   (
      .ref_clk_i (ref_clk_i),
      .hdr_o     (hdr)
   );

   // ==========================================================
   // 100 MHz clock and hang guard
   initial ref_clk_i = 1'b0;
   always #5 ref_clk_i = ~ref_clk_i;

   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         fails++;
         close_out;
      end
   end

   // ==========================================================
   // reporting
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task close_out;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ==========================================================
   // apb master: setup, access, hold until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      @(posedge ref_clk_i);
      while (pready !== 1'b1)
         @(posedge ref_clk_i);
      rd_word = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(rd_word, exp);
   endtask

   function automatic logic [31:0] ctl(input logic [2:0] ps, input logic [7:0] pv,
      input logic [1:0] t, input logic [1:0] f, input logic [1:0] o, input logic [1:0] s);
      return {8'h00, s, o, f, t, pv, 5'h00, ps};
   endfunction

   // one frame, then the one-cycle result and its end
   task automatic frame(input logic v4, input logic [7:0] pr, input logic [7:0] tt,
      input logic mf, input logic [12:0] fo, input logic op, input logic [31:0] sa,
      input logic exp);
      u_acl_hdr_src_model.send({1'b1, v4, pr, tt, mf, fo, op, sa});
      #1;
      chk({30'h0, hit_valid, hit}, {30'h0, 1'b1, exp});
      @(posedge ref_clk_i);
      #1;
      chk({31'h0, hit_valid}, 32'h00000000);
   endtask

   // ==========================================================
   // scenarios
   task automatic test_regs;
      rdc(ACL_OFS_CTRL, ACL_CTRL_RST);
      rdc(ACL_OFS_MASK, ACL_MASK_RST);
      rdc(ACL_OFS_ADDR, ACL_ADDR_RST);
      chk({31'h0, rd_err}, 32'h00000000);
      wr(ACL_OFS_CTRL, 32'hFFFFFFFF);
      rdc(ACL_OFS_CTRL, ACL_CTRL_WMASK);
      apb(1'b0, 12'h020, 32'h00000000);
      chk({31'h0, rd_err}, 32'h00000001);
      $display("test regs done");
   endtask

   task automatic test_proto;
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_ANY, 8'h00, TA, TA, TA, ACL_SRC_ANY));
      frame(HI, 8'h33, 8'h40, LO, 13'h0000, LO, SRC, HI);
      frame(LO, 8'h33, 8'h40, LO, 13'h0000, LO, SRC, LO);
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_SPECIFIC, 8'h00, TA, TA, TA, ACL_SRC_ANY));
      frame(HI, 8'h00, 8'h40, LO, 13'h0000, LO, SRC, HI);
      frame(HI, 8'h01, 8'h40, LO, 13'h0000, LO, SRC, LO);
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_SPECIFIC, 8'hFF, TA, TA, TA, ACL_SRC_ANY));
      frame(HI, 8'hFF, 8'h40, LO, 13'h0000, LO, SRC, HI);
      frame(HI, 8'hFE, 8'h40, LO, 13'h0000, LO, SRC, LO);
      // icmp, udp, tcp in turn: own number hits, a neighbour's misses
      for (int k = 0; k < 3; k++)
      begin
         psel_code = ACL_PROTO_ICMP + 3'(k);
         wr(ACL_OFS_CTRL, ctl(psel_code, 8'h00, TA, TA, TA, ACL_SRC_ANY));
         frame(HI, proto_num[k], 8'h40, LO, 13'h0000, LO, SRC, HI);
         frame(HI, proto_num[(k + 1) % 3], 8'h40, LO, 13'h0000, LO, SRC, LO);
         chk({29'h0, subparam_en}, 32'h00000001 << k);
         rdc(ACL_OFS_STATUS, 32'h00000004 << k);
      end
      $display("test proto done");
   endtask

   task automatic test_conds;
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_ANY, 8'h00, TN, TA, TA, ACL_SRC_ANY));
      frame(HI, 8'h06, 8'h00, LO, 13'h0000, LO, SRC, HI);
      frame(HI, 8'h06, 8'h01, LO, 13'h0000, LO, SRC, LO);
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_ANY, 8'h00, TY, TA, TA, ACL_SRC_ANY));
      frame(HI, 8'h06, 8'hFF, LO, 13'h0000, LO, SRC, HI);
      frame(HI, 8'h06, 8'h00, LO, 13'h0000, LO, SRC, LO);
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_ANY, 8'h00, TA, TN, TA, ACL_SRC_ANY));
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, LO, SRC, HI);
      frame(HI, 8'h06, 8'h40, HI, 13'h0000, LO, SRC, LO);
      frame(HI, 8'h06, 8'h40, LO, 13'h0001, LO, SRC, LO);
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_ANY, 8'h00, TA, TY, TA, ACL_SRC_ANY));
      frame(HI, 8'h06, 8'h40, LO, 13'h1FFF, LO, SRC, HI);
      frame(HI, 8'h06, 8'h40, HI, 13'h0000, LO, SRC, HI);
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, LO, SRC, LO);
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_ANY, 8'h00, TA, TA, TN, ACL_SRC_ANY));
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, LO, SRC, HI);
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, HI, SRC, LO);
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_ANY, 8'h00, TA, TA, TY, ACL_SRC_ANY));
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, HI, SRC, HI);
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, LO, SRC, LO);
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_ANY, 8'h00, TA, TA, TA, ACL_SRC_ANY));
      frame(HI, 8'h06, 8'h00, HI, 13'h0005, HI, SRC, HI);
      $display("test conds done");
   endtask

   task automatic test_source;
      wr(ACL_OFS_ADDR, SRC);
      wr(ACL_OFS_MASK, 32'hFFFFFF00);
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_ANY, 8'h00, TA, TA, TA, ACL_SRC_ANY));
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, LO, 32'h01020304, HI);
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_ANY, 8'h00, TA, TA, TA, ACL_SRC_HOST));
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, LO, SRC, HI);
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, LO, 32'hC0A80A04, LO);
      wr(ACL_OFS_CTRL, ctl(ACL_PROTO_ANY, 8'h00, TA, TA, TA, ACL_SRC_NET));
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, LO, 32'hC0A80AFE, HI);
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, LO, 32'hC0A80B05, LO);
      $display("test source done");
   endtask

   task automatic test_counts;
      wr(ACL_OFS_HITS, 32'h00000000);
      wr(ACL_OFS_FRAMES, 32'h00000000);
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, LO, SRC, HI);
      frame(HI, 8'h06, 8'h40, LO, 13'h0000, LO, 32'h0A000001, LO);
      rdc(ACL_OFS_HITS, 32'h00000001);
      rdc(ACL_OFS_FRAMES, 32'h00000002);
      $display("test counts done");
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      fails = 0;
      tests_run = 0;
      rst_i = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
      proto_num = '{ACL_IP_ICMP, ACL_IP_UDP, ACL_IP_TCP};
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      test_regs;
      test_proto;
      test_conds;
      test_source;
      test_counts;
      close_out;
   end

endmodule

// ### sim/acl_hdr_src_model.sv
// behavioural model of the ingress header parser feeding the matcher
`timescale 1ns/1ps

module acl_hdr_src_model
(
   input  wire logic              ref_clk_i,
   output acl_pkg::acl_hdr_s      hdr_o
);
   import acl_pkg::*;

   // ==========================================================
   // idle header: strobe low until the first frame is offered
   initial hdr_o = '0;

   // ==========================================================
   // one frame: fields and strobe together for exactly one cycle
   task automatic send(input acl_hdr_s f);
      @(posedge ref_clk_i);
      f.valid = 1'b1;
      hdr_o <= f;
      @(posedge ref_clk_i);
      // released fields turn over so stale values cannot pass as held
      f = ~f;
      f.valid = 1'b0;
      hdr_o <= f;
   endtask

endmodule
